// [design/ptfs_pkg.sv]
// Constants for the power and thermal fault status bank
package ptfs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RAIL_A_W = 8;
    localparam int RAIL_B_W = 5;
    localparam int SENSOR_N = 5;
    localparam int EVT_W = 4;
    localparam int SYNC_STAGES = 2;

    localparam logic [7:0] OFF_RAIL_A = 8'hb2;
    localparam logic [7:0] OFF_RAIL_B = 8'hb3;
    localparam logic [7:0] OFF_CRIT = 8'hb4;
    localparam logic [7:0] OFF_HOT = 8'hb5;
    localparam logic [7:0] OFF_EVT_STAT = 8'hc0;
    localparam logic [7:0] OFF_EVT_MASK = 8'hc1;

    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [3:0] RST_EVT_MASK = 4'h0;

    // First rail register bit positions
    localparam int RA_LDO_A2 = 7;
    localparam int RA_SW_A1 = 6;
    localparam int RA_STEP6 = 5;
    localparam int RA_STEP5 = 4;
    localparam int RA_STEP4 = 3;
    localparam int RA_STEP3 = 2;
    localparam int RA_STEP2 = 1;
    localparam int RA_STEP1 = 0;
    // Second rail register bit positions
    localparam int RB_LDO_A1 = 4;
    localparam int RB_TERM = 3;
    localparam int RB_SW_B2 = 2;
    localparam int RB_SW_B1 = 1;
    localparam int RB_LDO_A3 = 0;
    // Sensor positions, shared by critical and hot registers
    localparam int TS_REST_DIE = 4;
    localparam int TS_TERM = 3;
    localparam int TS_TOP_RIGHT = 2;
    localparam int TS_TOP_LEFT = 1;
    localparam int TS_BOT_RIGHT = 0;
    // Event summary bit positions
    localparam int EV_RAIL_A = 0;
    localparam int EV_RAIL_B = 1;
    localparam int EV_CRIT = 2;
    localparam int EV_HOT = 3;
endpackage

// [design/ptfs_sync.sv]
// Two-stage synchroniser for asynchronous fault levels
module ptfs_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// [design/ptfs_flags.sv]
// Sticky write-one-to-clear flag register
module ptfs_flags #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags_reg,
    output logic              new_evt
);
    logic [W-1:0] flags_next;

    // Set wins over clear; a live condition cannot be wiped
    always_comb begin
        flags_next = (flags_reg & ~clr) | cond;
    end

    // Only a flag going from clear to set is a fresh event
    assign new_evt = |(cond & ~flags_reg);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end
endmodule

// [design/ptfs_top.sv]
// Power and thermal fault status register bank
module ptfs_top (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    output logic            irq,
    input  wire logic       fault_ldo_rail_a2,
    input  wire logic       fault_switch_rail_a1,
    input  wire logic       fault_step_down_ctrl_6,
    input  wire logic       fault_step_down_ctrl_5,
    input  wire logic       fault_step_down_ctrl_4,
    input  wire logic       fault_step_down_ctrl_3,
    input  wire logic       fault_step_down_ctrl_2,
    input  wire logic       fault_step_down_ctrl_1,
    input  wire logic       fault_ldo_rail_a1,
    input  wire logic       fault_ddr_termination_ldo,
    input  wire logic       fault_switch_rail_b2,
    input  wire logic       fault_switch_rail_b1,
    input  wire logic       fault_ldo_rail_a3,
    input  wire logic [4:0] above_critical_threshold,
    input  wire logic [4:0] above_hot_threshold
);
    localparam int AW = ptfs_pkg::RAIL_A_W;
    localparam int BW = ptfs_pkg::RAIL_B_W;
    localparam int SN = ptfs_pkg::SENSOR_N;
    localparam int EW = ptfs_pkg::EVT_W;
    localparam int ALLW = AW + BW + 2 * SN;

    logic [AW-1:0]   raw_a;
    logic [BW-1:0]   raw_b;
    logic [ALLW-1:0] raw_all;
    logic [ALLW-1:0] sync_all;
    logic [AW-1:0]   cond_a;
    logic [BW-1:0]   cond_b;
    logic [SN-1:0]   cond_crit;
    logic [SN-1:0]   cond_hot;
    logic [AW-1:0]   clr_a;
    logic [BW-1:0]   clr_b;
    logic [SN-1:0]   clr_crit;
    logic [SN-1:0]   clr_hot;
    logic [AW-1:0]   flags_a;
    logic [BW-1:0]   flags_b;
    logic [SN-1:0]   flags_crit;
    logic [SN-1:0]   flags_hot;
    logic [EW-1:0]   evt;
    logic [EW-1:0]   evt_stat_reg;
    logic [EW-1:0]   evt_stat_next;
    logic [EW-1:0]   evt_mask_reg;
    logic [7:0]      rd_data_next;
    logic            first_reg;

    // Rail fault bit mapping
    assign raw_a[ptfs_pkg::RA_LDO_A2] = fault_ldo_rail_a2;
    assign raw_a[ptfs_pkg::RA_SW_A1] = fault_switch_rail_a1;
    assign raw_a[ptfs_pkg::RA_STEP6] = fault_step_down_ctrl_6;
    assign raw_a[ptfs_pkg::RA_STEP5] = fault_step_down_ctrl_5;
    assign raw_a[ptfs_pkg::RA_STEP4] = fault_step_down_ctrl_4;
    assign raw_a[ptfs_pkg::RA_STEP3] = fault_step_down_ctrl_3;
    assign raw_a[ptfs_pkg::RA_STEP2] = fault_step_down_ctrl_2;
    assign raw_a[ptfs_pkg::RA_STEP1] = fault_step_down_ctrl_1;
    assign raw_b[ptfs_pkg::RB_LDO_A1] = fault_ldo_rail_a1;
    assign raw_b[ptfs_pkg::RB_TERM] = fault_ddr_termination_ldo;
    assign raw_b[ptfs_pkg::RB_SW_B2] = fault_switch_rail_b2;
    assign raw_b[ptfs_pkg::RB_SW_B1] = fault_switch_rail_b1;
    assign raw_b[ptfs_pkg::RB_LDO_A3] = fault_ldo_rail_a3;

    // Sensor vectors arrive already in register bit order
    assign raw_all = {above_hot_threshold, above_critical_threshold,
                      raw_b, raw_a};

    // Analog comparators are asynchronous to clk
    ptfs_sync #(
        .W (ALLW)
    ) u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (raw_all),
        .sync_out (sync_all)
    );

    assign cond_a = sync_all[AW-1:0];
    assign cond_b = sync_all[AW+BW-1:AW];
    assign cond_crit = sync_all[AW+BW+SN-1:AW+BW];
    assign cond_hot = sync_all[ALLW-1:AW+BW+SN];

    // Write-one-to-clear strobes per register
    // Bus signals are arguments so the assigns follow them
    function automatic logic [7:0] w1c(input logic       we,
                                       input logic [7:0] a,
                                       input logic [7:0] d,
                                       input logic [7:0] off);
        w1c = (we && a == off) ? d : 8'h00;
    endfunction

    assign clr_a = w1c(wr_en, addr, wr_data,
                       ptfs_pkg::OFF_RAIL_A);
    assign clr_b = BW'(w1c(wr_en, addr, wr_data,
                           ptfs_pkg::OFF_RAIL_B));
    assign clr_crit = SN'(w1c(wr_en, addr, wr_data,
                              ptfs_pkg::OFF_CRIT));
    assign clr_hot = SN'(w1c(wr_en, addr, wr_data,
                             ptfs_pkg::OFF_HOT));

    ptfs_flags #(
        .W (AW)
    ) u_flags_a (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (cond_a),
        .clr       (clr_a),
        .flags_reg (flags_a),
        .new_evt   (evt[ptfs_pkg::EV_RAIL_A])
    );

    ptfs_flags #(
        .W (BW)
    ) u_flags_b (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (cond_b),
        .clr       (clr_b),
        .flags_reg (flags_b),
        .new_evt   (evt[ptfs_pkg::EV_RAIL_B])
    );

    // One instance per threshold, five sensors each
    ptfs_flags #(
        .W (SN)
    ) u_flags_crit (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (cond_crit),
        .clr       (clr_crit),
        .flags_reg (flags_crit),
        .new_evt   (evt[ptfs_pkg::EV_CRIT])
    );

    ptfs_flags #(
        .W (SN)
    ) u_flags_hot (
        .clk       (clk),
        .resetn    (resetn),
        .cond      (cond_hot),
        .clr       (clr_hot),
        .flags_reg (flags_hot),
        .new_evt   (evt[ptfs_pkg::EV_HOT])
    );

    // Event summary: set wins over write-one clear
    always_comb begin
        evt_stat_next = (evt_stat_reg
                         & ~EW'(w1c(wr_en, addr, wr_data,
                                    ptfs_pkg::OFF_EVT_STAT))) | evt;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_stat_reg <= '0;
        end else begin
            evt_stat_reg <= evt_stat_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_mask_reg <= ptfs_pkg::RST_EVT_MASK;
        end else if (wr_en && addr == ptfs_pkg::OFF_EVT_MASK) begin
            evt_mask_reg <= wr_data[EW-1:0];
        end
    end

    // Level output, one cycle behind the status it reflects
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_stat_reg & evt_mask_reg);
        end
    end

    // Narrow registers pad with zeros; unmapped reads give zero
    always_comb begin
        case (addr)
            ptfs_pkg::OFF_RAIL_A:   rd_data_next = flags_a;
            ptfs_pkg::OFF_RAIL_B:
                rd_data_next = {3'h0, flags_b};
            ptfs_pkg::OFF_CRIT:
                rd_data_next = {3'h0, flags_crit};
            ptfs_pkg::OFF_HOT:
                rd_data_next = {3'h0, flags_hot};
            ptfs_pkg::OFF_EVT_STAT: rd_data_next = {4'h0, evt_stat_reg};
            ptfs_pkg::OFF_EVT_MASK: rd_data_next = {4'h0, evt_mask_reg};
            default:                rd_data_next = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= ptfs_pkg::RST_FLAGS;
        end else if (rd_en) begin
            rd_data <= rd_data_next;
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Marks the first cycle after reset release, for checking only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_rail_a_set: assert property (
        (|cond_a) |=> ((flags_a & $past(cond_a)) == $past(cond_a)))
        else $error("rail a fault did not set its flag");

    a_rail_b_set: assert property (
        (|cond_b) |=> ((flags_b & $past(cond_b)) == $past(cond_b)))
        else $error("rail b fault did not set its flag");

    a_crit_pin_set: assert property (
        above_critical_threshold[ptfs_pkg::TS_REST_DIE]
        ##1 above_critical_threshold[ptfs_pkg::TS_REST_DIE]
        ##1 above_critical_threshold[ptfs_pkg::TS_REST_DIE]
        |=> flags_crit[ptfs_pkg::TS_REST_DIE])
        else $error("critical sensor did not set die flag");

    a_hot_pin_set: assert property (
        above_hot_threshold[ptfs_pkg::TS_BOT_RIGHT] [*3]
        |=> flags_hot[ptfs_pkg::TS_BOT_RIGHT])
        else $error("hot sensor did not set corner flag");

    a_rail_clear: assert property (
        (wr_en && addr == ptfs_pkg::OFF_RAIL_A)
        |=> ((flags_a & $past(wr_data) & ~$past(cond_a)) == 8'h00))
        else $error("write one did not clear rail flag");

    a_temp_clear: assert property (
        (wr_en && addr == ptfs_pkg::OFF_HOT)
        |=> ((flags_hot & $past(wr_data[4:0])
              & ~$past(cond_hot)) == 5'h00))
        else $error("write one did not clear hot flag");

    a_flag_holds: assert property (
        1'b1 |=> ((($past(flags_crit) & ~$past(clr_crit))
                   & ~flags_crit) == 5'h00))
        else $error("critical flag dropped without a clear");

    a_set_wins: assert property (
        (wr_en && addr == ptfs_pkg::OFF_RAIL_B && (|cond_b))
        |=> ((flags_b & $past(cond_b)) == $past(cond_b)))
        else $error("clearing write lost a live fault");

    a_crit_read: assert property (
        (rd_en && addr == ptfs_pkg::OFF_CRIT)
        |=> (rd_data == {3'h0, $past(flags_crit)}))
        else $error("critical register read mismatch");

    a_reserved_zero: assert property (
        (rd_en && (addr == ptfs_pkg::OFF_RAIL_B
                   || addr == ptfs_pkg::OFF_HOT))
        |=> (rd_data[7:5] == 3'h0))
        else $error("reserved bits read nonzero");

    a_reset_zero: assert property (
        first_reg |-> (flags_a == 8'h00 && flags_b == 5'h00
                       && flags_crit == 5'h00 && flags_hot == 5'h00))
        else $error("flags not zero after reset");

    a_irq_level: assert property (
        (|(evt_stat_reg & evt_mask_reg)) |=> irq)
        else $error("unmasked event did not raise interrupt");

    a_crit_clear: assert property (
        (wr_en && addr == ptfs_pkg::OFF_CRIT)
        |=> ((flags_crit & $past(wr_data[4:0])
              & ~$past(cond_crit)) == 5'h00))
        else $error("write one did not clear critical flag");

    a_zero_write: assert property (
        (wr_en && addr == ptfs_pkg::OFF_RAIL_A && wr_data == 8'h00)
        |=> ((flags_a & $past(flags_a)) == $past(flags_a)))
        else $error("writing zero changed a rail flag");

    a_hot_read: assert property (
        (rd_en && addr == ptfs_pkg::OFF_HOT)
        |=> (rd_data == {3'h0, $past(flags_hot)}))
        else $error("hot register read mismatch");

    a_rd_idle: assert property (
        (!rd_en) |=> (rd_data == 8'h00))
        else $error("read data not zero outside a read");

    a_irq_quiet: assert property (
        (!(|(evt_stat_reg & evt_mask_reg))) |=> (!irq))
        else $error("interrupt raised with no unmasked event");
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the power and thermal fault status bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       resetn;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       irq;
    logic [7:0] fa;
    logic [4:0] fb;
    logic [4:0] fc;
    logic [4:0] fh;
    logic       rd_seen;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int         n_errors;
    int         n_tests;

    localparam logic [7:0] ADDRS [4] = '{ptfs_pkg::OFF_RAIL_A,
        ptfs_pkg::OFF_RAIL_B, ptfs_pkg::OFF_CRIT, ptfs_pkg::OFF_HOT};

    ptfs_top u_ptfs_top (
        .clk                       (clk),
        .resetn                    (resetn),
        .addr                      (addr),
        .wr_data                   (wr_data),
        .wr_en                     (wr_en),
        .rd_en                     (rd_en),
        .rd_data                   (rd_data),
        .irq                       (irq),
        .fault_ldo_rail_a2         (fa[7]),
        .fault_switch_rail_a1      (fa[6]),
        .fault_step_down_ctrl_6    (fa[5]),
        .fault_step_down_ctrl_5    (fa[4]),
        .fault_step_down_ctrl_4    (fa[3]),
        .fault_step_down_ctrl_3    (fa[2]),
        .fault_step_down_ctrl_2    (fa[1]),
        .fault_step_down_ctrl_1    (fa[0]),
        .fault_ldo_rail_a1         (fb[4]),
        .fault_ddr_termination_ldo (fb[3]),
        .fault_switch_rail_b2      (fb[2]),
        .fault_switch_rail_b1      (fb[1]),
        .fault_ldo_rail_a3         (fb[0]),
        .above_critical_threshold  (fc),
        .above_hot_threshold       (fh)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic logic [7:0] wmask(input int r);
        return (r == 0) ? 8'hff : 8'h1f;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        // Reads still owed an answer count against the run
        if (exp_q.size() != 0) begin
            n_errors++;
        end
        $display("checks=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Every task that waits on the clock is entered just after a rising edge and ends on one
    task automatic step(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr  <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        exp_q.push_back(exp);
        @(posedge clk);
    endtask

    task automatic src(input int r, input logic [7:0] v);
        case (r)
            0: fa <= v;
            1: fb <= v[4:0];
            2: fc <= v[4:0];
            default: fh <= v[4:0];
        endcase
    endtask

    // Pulse a cause long enough to pass the synchroniser, then drop it
    task automatic pulse(input int r, input logic [7:0] v);
        src(r, v);
        step(2);
        src(r, 8'h00);
        step(4);
    endtask

    // Look at the level mid-cycle, then realign to a rising edge
    task automatic irq_chk(input logic exp);
        @(negedge clk);
        chk({7'h00, irq}, {7'h00, exp});
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_en;

    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, rd_data, 8'h00);
            end else begin
                chk(rd_data, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial begin
        logic [7:0] v;
        logic [7:0] m;
        resetn = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        fa = 8'h00;
        fb = 5'h00;
        fc = 5'h00;
        fh = 5'h00;
        seed = 32'haad46bc9;
        n_errors = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped places read zero
        foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
        rd(8'ha0, 8'h00);
        rd(8'hb6, 8'h00);
        step(2);
        $display("test reset_values done");
        // Each cause lands on its own bit and stays until cleared by a one
        for (int r = 0; r < 4; r++) begin
            m = wmask(r);
            for (int b = 0; b < 8; b++) begin
                if (m[b]) begin
                    pulse(r, 8'h01 << b);
                    rd(ADDRS[r], 8'h01 << b);
                    wr(ADDRS[r], 8'h00);
                    rd(ADDRS[r], 8'h01 << b);
                    wr(ADDRS[r], 8'h01 << b);
                    rd(ADDRS[r], 8'h00);
                end
            end
        end
        $display("test bit_mapping done");
        // Set wins over a clear; reserved bits stay zero
        for (int r = 0; r < 4; r++) begin
            src(r, 8'hff);
            step(4);
            wr(ADDRS[r], 8'hff);
            rd(ADDRS[r], wmask(r));
            src(r, 8'h00);
            step(3);
            wr(ADDRS[r], 8'hff);
            rd(ADDRS[r], 8'h00);
        end
        $display("test set_wins done");
        // Random patterns and partial clears
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            v = seed[7:0] & wmask(k % 4);
            m = seed[15:8];
            pulse(k % 4, v);
            rd(ADDRS[k % 4], v);
            wr(ADDRS[k % 4], m);
            rd(ADDRS[k % 4], v & ~m & wmask(k % 4));
            wr(ADDRS[k % 4], 8'hff);
        end
        $display("test random_clear done");
        // Interrupt: raised while masked, then enabled, then cleared
        // Every register has raised its event by now
        rd(ptfs_pkg::OFF_EVT_STAT, 8'h0f);
        wr(ptfs_pkg::OFF_EVT_STAT, 8'h0f);
        wr(ptfs_pkg::OFF_EVT_MASK, 8'h00);
        pulse(2, 8'h01 << ptfs_pkg::TS_TERM);
        irq_chk(1'b0);
        rd(ptfs_pkg::OFF_EVT_STAT, 8'h04);
        wr(ptfs_pkg::OFF_EVT_MASK, 8'h04);
        step(2);
        irq_chk(1'b1);
        rd(ptfs_pkg::OFF_EVT_MASK, 8'h04);
        wr(ptfs_pkg::OFF_EVT_STAT, 8'h04);
        step(2);
        irq_chk(1'b0);
        rd(ptfs_pkg::OFF_CRIT, 8'h08);
        $display("test interrupt done");
        // Reset in mid-run clears every flag
        src(1, 8'hff);
        step(4);
        resetn <= 1'b0;
        src(1, 8'h00);
        step(2);
        resetn <= 1'b1;
        step(1);
        rd(ptfs_pkg::OFF_RAIL_B, 8'h00);
        rd(ptfs_pkg::OFF_CRIT, 8'h00);
        rd(ptfs_pkg::OFF_EVT_MASK, 8'h00);
        step(3);
        $display("test mid_reset done");
        finish_test();
    end
endmodule
